// >>> src/irs_pkg.sv
// Behaviour
// - bytes are eight bits, msb first
// - start is sda fall with scl high
// - after start, shift address and direction
// - matching address acked low on ninth pulse
// - other address: stay idle, bus released
// - direction 0 writes, 1 reads
// - nine pulses: eight data, one ack
// - sda data changes only while scl low
// - stop aborts transfer, back to idle
// - first written byte loads the pointer
// - next bytes: upper then lower half
// - byte pair commits, then pointer advances
// - master writes even count of data bytes
// - pointer never wraps; data past maximum dropped
// - master ends write with stop/repeated start
// - master sets pointer before read transfer
// - read sends upper byte, lower, then advances
// - master acks between bytes, nack ends read
// - pointer at maximum resends last register
// - address upper five bits fixed
// - strap pins give low two bits
// - device is target only, never initiates
package irs_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_NS = 8;
	// host-made bus clock period, one quarter per host phase
	localparam int unsigned SCL_PERIOD_NS = 320;
	localparam logic [7:0] QTR_CYC = 8'(SCL_PERIOD_NS / (4 * CLK_NS));

	// ---------------------------------------------------------------
	// framing and addressing
	// ---------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [4:0] DEV_ADDR_HI = 5'h0B;
	localparam logic [7:0] PTR_MAX = 8'hFF;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ---------------------------------------------------------------
	// state and command types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_AACK, D_WR, D_WACK, D_RD, D_RACK
	} irs_dev_st_t;

	typedef enum logic [1:0] {
		H_IDLE, H_COND, H_BYTE
	} irs_host_st_t;

	typedef enum logic [2:0] {
		OP_START, OP_WRITE, OP_READ_ACK, OP_READ_NACK, OP_STOP
	} irs_op_t;

endpackage

// >>> src/irs_if.sv
// ---------------------------------------------------------------
// two-wire bus with pull-ups: a released line reads high
// ---------------------------------------------------------------
interface irs_if;
	logic host_scl;
	logic host_scl_oe_b;
	logic host_sda;
	logic host_sda_oe_b;
	logic dev_sda;
	logic dev_sda_oe_b;
	logic scl;
	logic sda;

	// wired-and of every driver that is enabled
	assign scl = host_scl_oe_b | host_scl;
	assign sda = (host_sda_oe_b | host_sda) & (dev_sda_oe_b | dev_sda);

	modport host (
		output host_scl, host_scl_oe_b, host_sda, host_sda_oe_b,
		input scl, sda
	);
	modport dev (
		output dev_sda, dev_sda_oe_b,
		input scl, sda
	);
endinterface

// >>> src/irs_device.sv
module irs_device (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// address strap pins
	input wire logic i_addr_select_high,
	input wire logic i_addr_select_low,
	// register file side
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [15:0] o_wr_data,
	output logic [7:0] o_rd_addr,
	input wire logic [15:0] i_rd_data,
	// two-wire bus
	irs_if.dev bus
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [2:0] scl_sh_ff;
	logic [2:0] sda_sh_ff;
	logic [1:0] sel_hi_ff;
	logic [1:0] sel_lo_ff;
	irs_pkg::irs_dev_st_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shreg_ff, nxt_shreg;
	logic [7:0] ptr_ff, nxt_ptr;
	logic [7:0] hi_ff, nxt_hi;
	logic half_ff, nxt_half;
	logic first_ff, nxt_first;
	logic full_ff, nxt_full;
	logic rw_ff, nxt_rw;
	logic nack_ff, nxt_nack;
	logic tx_lo_ff, nxt_tx_lo;
	logic oe_b_ff, nxt_oe_b;
	logic wr_en_ff, nxt_wr_en;
	logic [7:0] wr_addr_ff, nxt_wr_addr;
	logic [15:0] wr_data_ff, nxt_wr_data;
	logic do_load;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	// stage 0 feeds stage 1 only; edges come from stages 1 and 2
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_sh_ff <= 3'h7;
			sda_sh_ff <= 3'h7;
			sel_hi_ff <= 2'h0;
			sel_lo_ff <= 2'h0;
		end else begin
			scl_sh_ff <= {scl_sh_ff[1:0], bus.scl};
			sda_sh_ff <= {sda_sh_ff[1:0], bus.sda};
			sel_hi_ff <= {sel_hi_ff[0], i_addr_select_high};
			sel_lo_ff <= {sel_lo_ff[0], i_addr_select_low};
		end
	end

	// ---------------------------------------------------------------
	// bus event decode
	// ---------------------------------------------------------------
	// edges seen on the synchronised copies, two cycles late
	wire scl_hi = scl_sh_ff[1] & scl_sh_ff[2];
	wire scl_rise = scl_sh_ff[1] & ~scl_sh_ff[2];
	wire scl_fall = ~scl_sh_ff[1] & scl_sh_ff[2];
	wire sda_now = sda_sh_ff[1];
	// sda moving while scl high is a condition, never data
	wire start_det = scl_hi & sda_sh_ff[2] & ~sda_sh_ff[1];
	wire stop_det = scl_hi & ~sda_sh_ff[2] & sda_sh_ff[1];
	wire byte_done = cnt_ff == irs_pkg::BYTE_BITS;

	// own address: fixed upper bits plus the two straps
	wire [6:0] own_addr = {irs_pkg::DEV_ADDR_HI, sel_hi_ff[1], sel_lo_ff[1]};
	wire addr_match = shreg_ff[7:1] == own_addr;
	wire ptr_at_max = ptr_ff == irs_pkg::PTR_MAX;
	// upper half goes out first
	wire [7:0] tx_byte = tx_lo_ff ? i_rd_data[7:0] : i_rd_data[15:8];
	wire [7:0] ptr_inc = ptr_ff + 8'h01;

	// ---------------------------------------------------------------
	// transfer state machine
	// ---------------------------------------------------------------
	// all sda changes follow a seen scl fall, so the line only
	// moves while scl is low
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shreg = shreg_ff;
		nxt_ptr = ptr_ff;
		nxt_hi = hi_ff;
		nxt_half = half_ff;
		nxt_first = first_ff;
		nxt_full = full_ff;
		nxt_rw = rw_ff;
		nxt_nack = nack_ff;
		nxt_tx_lo = tx_lo_ff;
		nxt_oe_b = oe_b_ff;
		nxt_wr_en = 1'b0;
		nxt_wr_addr = wr_addr_ff;
		nxt_wr_data = wr_data_ff;
		do_load = 1'b0;
		if (stop_det) begin
			nxt_state = irs_pkg::D_IDLE;
			nxt_oe_b = 1'b1;
			nxt_half = 1'b0;
		end else if (start_det) begin
			// also a repeated start: any held half pair is lost
			nxt_state = irs_pkg::D_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe_b = 1'b1;
			nxt_half = 1'b0;
			nxt_first = 1'b1;
			nxt_tx_lo = 1'b0;
		end else begin
			case (state_ff)
				irs_pkg::D_IDLE: begin
					// released; waits for the next start
					nxt_oe_b = 1'b1;
				end
				irs_pkg::D_ADDR: begin
					if (scl_rise) begin
						nxt_shreg = {shreg_ff[6:0], sda_now};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (addr_match) begin
							nxt_state = irs_pkg::D_AACK;
							nxt_oe_b = 1'b0;
							nxt_rw = shreg_ff[0];
						end else begin
							nxt_state = irs_pkg::D_IDLE;
						end
					end
				end
				irs_pkg::D_AACK: begin
					if (scl_fall) begin
						if (rw_ff) begin
							do_load = 1'b1;
						end else begin
							nxt_state = irs_pkg::D_WR;
							nxt_cnt = 4'h0;
							nxt_oe_b = 1'b1;
						end
					end
				end
				irs_pkg::D_WR: begin
					if (scl_rise) begin
						nxt_shreg = {shreg_ff[6:0], sda_now};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && byte_done) begin
						nxt_state = irs_pkg::D_WACK;
						nxt_oe_b = 1'b0;
						if (first_ff) begin
							nxt_ptr = shreg_ff;
							nxt_first = 1'b0;
							nxt_full = 1'b0;
						end else if (full_ff) begin
							nxt_half = 1'b0;
						end else if (!half_ff) begin
							nxt_hi = shreg_ff;
							nxt_half = 1'b1;
						end else begin
							nxt_wr_en = 1'b1;
							nxt_wr_addr = ptr_ff;
							nxt_wr_data = {hi_ff, shreg_ff};
							nxt_half = 1'b0;
							if (ptr_at_max) begin
								nxt_full = 1'b1;
							end else begin
								nxt_ptr = ptr_inc;
							end
						end
					end
				end
				irs_pkg::D_WACK: begin
					if (scl_fall) begin
						nxt_state = irs_pkg::D_WR;
						nxt_cnt = 4'h0;
						nxt_oe_b = 1'b1;
					end
				end
				irs_pkg::D_RD: begin
					if (scl_rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (byte_done) begin
							// hand the ninth pulse to the master
							nxt_state = irs_pkg::D_RACK;
							nxt_oe_b = 1'b1;
						end else begin
							nxt_shreg = {shreg_ff[6:0], 1'b0};
							nxt_oe_b = shreg_ff[6];
						end
					end
				end
				irs_pkg::D_RACK: begin
					if (scl_rise) begin
						nxt_nack = sda_now;
					end else if (scl_fall) begin
						if (nack_ff) begin
							nxt_state = irs_pkg::D_IDLE;
						end else begin
							do_load = 1'b1;
						end
					end
				end
				default: begin
					nxt_state = irs_pkg::D_IDLE;
					nxt_oe_b = 1'b1;
				end
			endcase
		end
		// next read byte: drive its msb now, in the low phase
		if (do_load) begin
			nxt_state = irs_pkg::D_RD;
			nxt_cnt = 4'h0;
			nxt_shreg = tx_byte;
			nxt_oe_b = tx_byte[7];
			nxt_tx_lo = ~tx_lo_ff;
			// advance once the lower half is captured; stall at top
			if (tx_lo_ff && !ptr_at_max) begin
				nxt_ptr = ptr_inc;
			end
		end
	end

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff <= irs_pkg::D_IDLE;
			cnt_ff <= 4'h0;
			shreg_ff <= irs_pkg::BYTE_RST;
			ptr_ff <= irs_pkg::PTR_RST;
			hi_ff <= irs_pkg::BYTE_RST;
			half_ff <= 1'b0;
			first_ff <= 1'b1;
			full_ff <= 1'b0;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			tx_lo_ff <= 1'b0;
			oe_b_ff <= 1'b1;
			wr_en_ff <= 1'b0;
			wr_addr_ff <= irs_pkg::PTR_RST;
			wr_data_ff <= irs_pkg::WORD_RST;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shreg_ff <= nxt_shreg;
			ptr_ff <= nxt_ptr;
			hi_ff <= nxt_hi;
			half_ff <= nxt_half;
			first_ff <= nxt_first;
			full_ff <= nxt_full;
			rw_ff <= nxt_rw;
			nack_ff <= nxt_nack;
			tx_lo_ff <= nxt_tx_lo;
			oe_b_ff <= nxt_oe_b;
			wr_en_ff <= nxt_wr_en;
			wr_addr_ff <= nxt_wr_addr;
			wr_data_ff <= nxt_wr_data;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// open drain: the data pin only ever pulls low
	assign bus.dev_sda = 1'b0;
	assign bus.dev_sda_oe_b = oe_b_ff;
	assign o_wr_en = wr_en_ff;
	assign o_wr_addr = wr_addr_ff;
	assign o_wr_data = wr_data_ff;
	assign o_rd_addr = ptr_ff;

endmodule

// >>> src/irs_host.sv
module irs_host (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// command side
	input wire logic i_cmd_valid,
	input wire irs_pkg::irs_op_t i_cmd_op,
	input wire logic [7:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_ack,
	output logic [7:0] o_rd_data,
	// two-wire bus
	irs_if.host bus
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [1:0] sda_sh_ff;
	irs_pkg::irs_host_st_t state_ff, nxt_state;
	irs_pkg::irs_op_t op_ff, nxt_op;
	logic [7:0] qcnt_ff, nxt_qcnt;
	logic [1:0] ph_ff, nxt_ph;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] rx_ff, nxt_rx;
	logic scl_ff, nxt_scl;
	logic sda_ff, nxt_sda;
	logic ack_ff, nxt_ack;
	logic done_ff, nxt_done;
	logic rdy_ff, nxt_rdy;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire take = rdy_ff & i_cmd_valid;
	wire busy = state_ff != irs_pkg::H_IDLE;
	// quarter-period enable from the divider
	wire tick = busy & (qcnt_ff == irs_pkg::QTR_CYC - 8'h01);
	wire is_wr = op_ff == irs_pkg::OP_WRITE;
	wire is_start = op_ff == irs_pkg::OP_START;
	wire ack_bit = bit_ff == irs_pkg::BYTE_BITS;
	// data bit, then released or acked ninth bit
	wire wr_bit = is_wr ? tx_ff[7] : 1'b1;
	wire ninth_bit = is_wr ? 1'b1 : (op_ff == irs_pkg::OP_READ_NACK);

	// ---------------------------------------------------------------
	// phase sequencer
	// ---------------------------------------------------------------
	// ph0 sets sda with scl low, ph1 raises scl, ph2 samples,
	// ph3 lowers scl; conditions reuse the same four quarters
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_qcnt = tick ? 8'h00 : (busy ? qcnt_ff + 8'h01 : 8'h00);
		nxt_ph = ph_ff;
		nxt_bit = bit_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_scl = scl_ff;
		nxt_sda = sda_ff;
		nxt_ack = ack_ff;
		nxt_done = 1'b0;
		nxt_rdy = rdy_ff;
		if (take) begin
			nxt_op = i_cmd_op;
			nxt_tx = i_cmd_data;
			nxt_ph = 2'h0;
			nxt_bit = 4'h0;
			nxt_rdy = 1'b0;
			nxt_state = (i_cmd_op == irs_pkg::OP_START || i_cmd_op == irs_pkg::OP_STOP) ?
				irs_pkg::H_COND : irs_pkg::H_BYTE;
		end else if (tick) begin
			nxt_ph = ph_ff + 2'h1;
			case (state_ff)
				irs_pkg::H_COND: begin
					case (ph_ff)
						2'h0: nxt_sda = is_start;
						2'h1: nxt_scl = 1'b1;
						// sda edge with scl high
						2'h2: nxt_sda = ~is_start;
						default: begin
							nxt_scl = ~is_start;
							nxt_state = irs_pkg::H_IDLE;
							nxt_done = 1'b1;
							nxt_rdy = 1'b1;
						end
					endcase
				end
				irs_pkg::H_BYTE: begin
					case (ph_ff)
						2'h0: nxt_sda = ack_bit ? ninth_bit : wr_bit;
						2'h1: nxt_scl = 1'b1;
						2'h2: begin
							if (ack_bit) begin
								nxt_ack = ~sda_sh_ff[1];
							end else begin
								nxt_rx = {rx_ff[6:0], sda_sh_ff[1]};
								nxt_tx = {tx_ff[6:0], 1'b0};
							end
						end
						default: begin
							nxt_scl = 1'b0;
							nxt_bit = bit_ff + 4'h1;
							if (ack_bit) begin
								nxt_state = irs_pkg::H_IDLE;
								nxt_done = 1'b1;
								nxt_rdy = 1'b1;
							end
						end
					endcase
				end
				default: nxt_state = irs_pkg::H_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sda_sh_ff <= 2'h3;
			state_ff <= irs_pkg::H_IDLE;
			op_ff <= irs_pkg::OP_START;
			qcnt_ff <= 8'h00;
			ph_ff <= 2'h0;
			bit_ff <= 4'h0;
			tx_ff <= irs_pkg::BYTE_RST;
			rx_ff <= irs_pkg::BYTE_RST;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			ack_ff <= 1'b0;
			done_ff <= 1'b0;
			rdy_ff <= 1'b1;
		end else begin
			sda_sh_ff <= {sda_sh_ff[0], bus.sda};
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			qcnt_ff <= nxt_qcnt;
			ph_ff <= nxt_ph;
			bit_ff <= nxt_bit;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			scl_ff <= nxt_scl;
			sda_ff <= nxt_sda;
			ack_ff <= nxt_ack;
			done_ff <= nxt_done;
			rdy_ff <= nxt_rdy;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// both lines open drain: level 0 means enable the pull-down
	assign bus.host_scl = 1'b0;
	assign bus.host_scl_oe_b = scl_ff;
	assign bus.host_sda = 1'b0;
	assign bus.host_sda_oe_b = sda_ff;
	assign o_cmd_ready = rdy_ff;
	assign o_done = done_ff;
	assign o_ack = ack_ff;
	assign o_rd_data = rx_ff;

endmodule

// >>> tb/irs_sva.sv
module irs_sva (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// bus drivers and resolved lines
	input wire logic host_scl,
	input wire logic host_scl_oe_b,
	input wire logic host_sda,
	input wire logic host_sda_oe_b,
	input wire logic dev_sda,
	input wire logic dev_sda_oe_b,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// wire rules
	// ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	// device moves sda only in the low phase, a few cycles after the fall
	dev_edge_low_a: assert property ($changed(dev_sda_oe_b) |-> !scl)
		else $error("device moved sda with scl high");
	dev_lag_a: assert property ($changed(dev_sda_oe_b) |-> !$past(scl, 2) && $past(scl, 5))
		else $error("device sda change out of step with scl fall");
	// ack or data held for eight cycles after each scl rise
	ack_hold_a: assert property ($rose(scl) && !dev_sda_oe_b |=> !dev_sda_oe_b [*8])
		else $error("device released sda during high phase");
	stop_idle_a: assert property (scl && $rose(sda) |=> dev_sda_oe_b [*8])
		else $error("device drives after stop");
	// host data edges sit in the low phase; only conditions fall well inside high
	host_cond_a: assert property (scl && $changed(host_sda_oe_b) |-> $past(scl, 5))
		else $error("host sda edge too near scl rise");
	scl_pulse_a: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high phase too short");
	start_free_a: assert property (scl && $fell(sda) |-> dev_sda_oe_b && !host_sda_oe_b)
		else $error("start not made by host alone");
	pull_low_a: assert property (!dev_sda_oe_b |-> !dev_sda && !sda)
		else $error("device enable without low level");

	// main scenarios reached
	dev_ack_c: cover property ($fell(dev_sda_oe_b));
	start_c: cover property (scl && $fell(sda));
	stop_c: cover property (scl && $rose(sda));
endmodule

// >>> tb/tb_i2c_register_slave.sv
module tb_i2c_register_slave;
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// signals
	// ----
	logic i_clk;
	logic i_rst_b;
	logic sel_hi;
	logic sel_lo;
	logic cmd_valid;
	irs_pkg::irs_op_t cmd_op;
	logic [7:0] cmd_data;
	logic cmd_ready;
	logic done;
	logic ack;
	logic [7:0] rd_byte;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [7:0] rd_addr;
	logic [15:0] rd_data;
	logic [15:0] regs [256];
	logic [15:0] mon_sh;
	logic [6:0] dev_addr;
	int commits;
	int mismatches;
	int total_checks;

	irs_if irs_if_i ();
	irs_host irs_host_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
		.i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_done(done), .o_ack(ack), .o_rd_data(rd_byte),
		.bus(irs_if_i));
	irs_device irs_device_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr_select_high(sel_hi),
		.i_addr_select_low(sel_lo), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
		.o_rd_addr(rd_addr), .i_rd_data(rd_data), .bus(irs_if_i));
	irs_sva irs_sva_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .host_scl(irs_if_i.host_scl),
		.host_scl_oe_b(irs_if_i.host_scl_oe_b), .host_sda(irs_if_i.host_sda),
		.host_sda_oe_b(irs_if_i.host_sda_oe_b), .dev_sda(irs_if_i.dev_sda),
		.dev_sda_oe_b(irs_if_i.dev_sda_oe_b), .scl(irs_if_i.scl), .sda(irs_if_i.sda));

	// register file behind the device, read combinationally
	assign rd_data = regs[rd_addr];
	always @(posedge i_clk) if (wr_en === 1'b1) begin
		regs[wr_addr] <= wr_data;
		commits <= commits + 1;
	end
	// wire monitor: bits as seen at each scl rise
	always @(posedge irs_if_i.scl) mon_sh <= {mon_sh[14:0], irs_if_i.sda};
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ----
	// checking and commands
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one host command, bounded wait on its done pulse
	task automatic op(input irs_pkg::irs_op_t o, input logic [7:0] d);
		int n;
		n = 0;
		// host must be free again before the next command is offered
		chk(16'(cmd_ready), 16'h0001);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		@(posedge i_clk);
		#1;
		cmd_valid = 1'b0;
		while (done !== 1'b1) begin
			@(posedge i_clk);
			#1;
			n++;
			if (n > 1000) begin
				mismatches++;
				$display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
				complete_run();
			end
		end
	endtask
	task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
		op(irs_pkg::OP_WRITE, d);
		chk(16'(ack), 16'(exp_ack));
		chk(16'(mon_sh[8:1]), 16'(d));
		chk(16'(mon_sh[0]), 16'(!exp_ack));
	endtask
	task automatic rd_chk(input logic [7:0] exp, input logic last);
		op(last ? irs_pkg::OP_READ_NACK : irs_pkg::OP_READ_ACK, 8'h00);
		chk(16'(rd_byte), 16'(exp));
		chk(16'(mon_sh[8:1]), 16'(exp));
		chk(16'(mon_sh[0]), 16'(last));
	endtask
	task automatic begin_xfer(input logic [6:0] a, input logic rd, input logic exp_ack);
		op(irs_pkg::OP_START, 8'h00);
		wr_byte({a, rd}, exp_ack);
	endtask
	task automatic set_ptr(input logic [7:0] p);
		begin_xfer(dev_addr, 1'b0, 1'b1);
		wr_byte(p, 1'b1);
	endtask
	task automatic wr_words(input logic [7:0] p, input logic [15:0] ws[$]);
		set_ptr(p);
		// whole words only, so the byte count stays even
		foreach (ws[i]) begin
			wr_byte(ws[i][15:8], 1'b1);
			wr_byte(ws[i][7:0], 1'b1);
		end
		op(irs_pkg::OP_STOP, 8'h00);
	endtask
	// pointer set, then repeated start into the read
	task automatic rd_words(input logic [7:0] p, input logic [15:0] ws[$]);
		set_ptr(p);
		begin_xfer(dev_addr, 1'b1, 1'b1);
		foreach (ws[i]) begin
			rd_chk(ws[i][15:8], 1'b0);
			rd_chk(ws[i][7:0], 1'(i == ws.size() - 1));
		end
		op(irs_pkg::OP_STOP, 8'h00);
	endtask

	// ----
	// scenarios
	// ----
	task automatic sc_write_read;
		int c0;
		c0 = commits;
		wr_words(8'h10, '{16'hA53C, 16'h1234});
		chk(regs[8'h10], 16'hA53C);
		chk(regs[8'h11], 16'h1234);
		chk(16'(commits - c0), 16'h0002);
		rd_words(8'h10, '{16'hA53C, 16'h1234});
	endtask
	// reset inside an open write: both ends back to released idle
	task automatic sc_reset;
		set_ptr(8'h40);
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_clk);
		#1;
		chk(16'({irs_if_i.scl, irs_if_i.sda}), 16'h0003);
		chk(16'(rd_addr), 16'(irs_pkg::PTR_RST));
		chk(16'(wr_en), 16'h0000);
		chk(16'(cmd_ready), 16'h0001);
		i_rst_b = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		rd_words(8'h11, '{16'h1234});
	endtask
	// lone half dropped at repeated start and at stop
	task automatic sc_odd_byte;
		int c0;
		c0 = commits;
		set_ptr(8'h20);
		wr_byte(8'h11, 1'b1);
		wr_byte(8'h22, 1'b1);
		wr_byte(8'h33, 1'b1);
		op(irs_pkg::OP_START, 8'h00);
		op(irs_pkg::OP_STOP, 8'h00);
		set_ptr(8'h30);
		wr_byte(8'h44, 1'b1);
		op(irs_pkg::OP_STOP, 8'h00);
		chk(regs[8'h20], 16'h1122);
		chk(regs[8'h21], 16'h21DE);
		chk(regs[8'h30], 16'h30CF);
		chk(16'(commits - c0), 16'h0001);
	endtask
	// pointer stops at the top: writes dropped, reads repeat
	task automatic sc_pointer_max;
		int c0;
		c0 = commits;
		wr_words(8'hFE, '{16'hBEEF, 16'hCAFE, 16'h5555});
		chk(regs[8'hFF], 16'hCAFE);
		chk(regs[8'h00], 16'h00FF);
		chk(16'(commits - c0), 16'h0002);
		rd_words(8'hFE, '{16'hBEEF, 16'hCAFE, 16'hCAFE});
	endtask
	// every strap setting against every low address pair
	task automatic sc_address;
		for (int s = 0; s < 4; s++) begin
			{sel_hi, sel_lo} = 2'(s);
			repeat (4) @(posedge i_clk);
			#1;
			for (int w = 0; w < 5; w++) begin
				dev_addr = {(w == 4) ? 5'h0A : irs_pkg::DEV_ADDR_HI, 2'(w)};
				begin_xfer(dev_addr, 1'b0, 1'(w == s));
				if (w != s) wr_byte(8'h00, 1'b0);
				op(irs_pkg::OP_STOP, 8'h00);
			end
		end
	endtask

	initial begin
		cmd_valid = 1'b0;
		cmd_op = irs_pkg::OP_START;
		cmd_data = 8'h00;
		{sel_hi, sel_lo} = 2'b10;
		i_rst_b = 1'b0;
		mismatches = 0;
		total_checks = 0;
		commits = 0;
		mon_sh = 16'h0000;
		for (int i = 0; i < 256; i++) regs[i] = {8'(i), ~8'(i)};
		dev_addr = {irs_pkg::DEV_ADDR_HI, 2'b10};
		repeat (16) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		chk(16'({irs_if_i.scl, irs_if_i.sda}), 16'h0003);
		sc_write_read();
		sc_reset();
		sc_odd_byte();
		sc_pointer_max();
		sc_address();
		complete_run();
	end
endmodule
